// ### src/mac_hash_filter_queue_thresholds.sv
`timescale 1ns/1ns
// Contract
// - monitor on: flag status when space suffices
// - 64-bit hash table used in hash mode
// - index is top six crc bits of address
// - top two pick word, four pick bit
// - hash bit one accepts, zero drops
// - accept-all controls pass every multicast frame
// - 12-bit low watermark, reset 0x500
// - 12-bit high watermark, reset 0x300
module mac_hash_filter_queue_thresholds (
	input  wire logic        i_clock,        // 25 mhz system clock
	input  wire logic        i_rst_n,        // async reset, active low
	input  wire logic        psel,           // apb select
	input  wire logic        penable,        // apb enable
	input  wire logic        pwrite,         // apb direction
	input  wire logic [11:0] paddr,          // apb byte address
	input  wire logic [31:0] pwdata,         // apb write data
	output logic      [31:0] prdata,         // apb read data
	output logic             pready,         // apb ready
	output logic             pslverr,        // apb error, unmapped
	input  wire logic [15:0] i_tx_free_words, // free tx queue dwords
	input  wire logic [11:0] i_rx_free_words, // free rx queue dwords
	input  wire logic        i_da_valid,     // destination address strobe
	input  wire logic [47:0] i_da,           // address, first octet [47:40]
	input  wire logic        i_hash_mode,    // hash-perfect filter selected
	output logic             o_da_done,      // filter verdict pulse
	output logic             o_da_accept,    // frame accepted
	output logic             o_tx_space_avail, // tx space status level
	output logic             o_flow_active   // flow control asserted
);
	import mac_filter_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	logic [15:0]         tx_space_request;  // requested dwords
	logic [63:0]         hash_table;        // four hash words
	logic [MARK_W-1:0]   rx_flow_low_mark;  // release level
	logic [MARK_W-1:0]   rx_flow_high_mark; // assert level
	logic [15:0]         tx_queue_control;  // monitor enable
	logic [15:0]         interrupt_status;  // sticky status
	logic [15:0]         receive_control_one; // accept-all bits
	logic                tx_cond_q;         // last space condition
	logic [HASH_IDX_W-1:0] hash_idx_q;      // last hash index

	// ****************************************
	// bus decode
	// ****************************************
	logic [9:0]  idx;        // register index
	logic        wr_en;      // write takes effect
	logic        rd_setup;   // read setup cycle
	logic        mapped;     // address hits a register
	logic [15:0] rd_val;     // decoded read value

	assign idx      = paddr[11:2];
	assign wr_en    = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready   = 1'b1;

	// address decode and read mux
	always_comb begin
		mapped = (paddr[1:0] == 2'b00);
		rd_val = 16'h0000;
		unique case (idx)
			IDX_TX_SPACE_REQ: rd_val = tx_space_request;
			IDX_HASH_WORD0:   rd_val = hash_table[15:0];
			IDX_HASH_WORD1:   rd_val = hash_table[31:16];
			IDX_HASH_WORD2:   rd_val = hash_table[47:32];
			IDX_HASH_WORD3:   rd_val = hash_table[63:48];
			IDX_RX_LOW_MARK:  rd_val = {4'h0, rx_flow_low_mark};
			IDX_RX_HIGH_MARK: rd_val = {4'h0, rx_flow_high_mark};
			IDX_TX_QUEUE_CTL: rd_val = tx_queue_control;
			IDX_INT_STATUS:   rd_val = interrupt_status;
			IDX_RX_CTL_ONE:   rd_val = receive_control_one;
			default:          mapped = 1'b0; // unmapped index
		endcase
		// misaligned or unmapped reads return zero, never a register
		if (!mapped) begin
			rd_val = 16'h0000;
		end
	end

	// error only in access phase of an unmapped transfer
	assign pslverr = psel & penable & ~mapped;

	// read data captured in setup, stable through access
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= {16'h0000, rd_val};
		end
	end

	// ****************************************
	// writable registers
	// ****************************************
	// plain read/write registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_space_request    <= RST_TX_SPACE_REQ;
			hash_table          <= {4{RST_HASH_WORD}};
			rx_flow_low_mark    <= RST_LOW_MARK;
			rx_flow_high_mark   <= RST_HIGH_MARK;
			tx_queue_control    <= RST_CTL_WORD;
			receive_control_one <= RST_CTL_WORD;
		end else if (wr_en) begin
			unique case (idx)
				IDX_TX_SPACE_REQ: tx_space_request <= pwdata[15:0];
				IDX_HASH_WORD0:   hash_table[15:0]  <= pwdata[15:0];
				IDX_HASH_WORD1:   hash_table[31:16] <= pwdata[15:0];
				IDX_HASH_WORD2:   hash_table[47:32] <= pwdata[15:0];
				IDX_HASH_WORD3:   hash_table[63:48] <= pwdata[15:0];
				IDX_RX_LOW_MARK:  rx_flow_low_mark  <= pwdata[11:0];
				IDX_RX_HIGH_MARK: rx_flow_high_mark <= pwdata[11:0];
				IDX_TX_QUEUE_CTL: tx_queue_control  <= pwdata[15:0];
				IDX_RX_CTL_ONE:   receive_control_one <= pwdata[15:0];
				default: begin
					// status and others not written here
				end
			endcase
		end
	end

	// ****************************************
	// tx space available status
	// ****************************************
	logic tx_cond;  // monitor on and enough free space
	logic tx_rise;  // condition just became true
	assign tx_cond = tx_queue_control[TXQ_MON_BIT] &
		(i_tx_free_words >= tx_space_request);
	assign tx_rise = tx_cond & ~tx_cond_q;

	// edge memory so the flag is raised once per occurrence
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_cond_q <= 1'b0;
		end else begin
			tx_cond_q <= tx_cond;
		end
	end

	// sticky status, write one clears, set wins over clear
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			interrupt_status <= RST_CTL_WORD;
		end else if (tx_rise) begin
			interrupt_status[INT_TXSP_BIT] <= 1'b1;
		end else if (wr_en && idx == IDX_INT_STATUS && pwdata[INT_TXSP_BIT]) begin
			interrupt_status[INT_TXSP_BIT] <= 1'b0;
		end
	end
	assign o_tx_space_avail = interrupt_status[INT_TXSP_BIT];

	// ****************************************
	// multicast hash filter
	// ****************************************
	// crc over the address, octets first to last, lsb first
	function automatic logic [HASH_IDX_W-1:0] crc_top(input logic [47:0] da);
		logic [31:0] crc;
		logic        fb;
		crc = CRC_INIT;
		fb  = 1'b0;
		for (int o = 0; o < 6; o++) begin
			for (int b = 0; b < 8; b++) begin
				fb  = crc[31] ^ da[47 - 8*o - 7 + b];
				crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
			end
		end
		crc_top = crc[31:26];
	endfunction : crc_top

	logic [HASH_IDX_W-1:0] hash_idx;  // current index
	logic                  hash_bit;  // selected table bit
	logic                  is_mcast;  // group address
	logic                  accept_all; // accept-all controls
	logic                  verdict;   // accept decision

	assign hash_idx   = crc_top(i_da);
	assign hash_bit   = hash_table[{hash_idx[5:4], hash_idx[3:0]}];
	assign is_mcast   = i_da[40];
	assign accept_all = receive_control_one[RX_ALL_BIT] |
		receive_control_one[RX_ALLMC_BIT];

	// decision: non-group and non-hash modes pass untouched
	always_comb begin
		verdict = 1'b1;
		if (is_mcast && !accept_all && i_hash_mode) begin
			verdict = hash_bit;
		end else if (is_mcast && accept_all) begin
			verdict = 1'b1;
		end
	end

	// registered verdict, one cycle after the strobe
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_da_done   <= 1'b0;
			o_da_accept <= 1'b0;
			hash_idx_q  <= '0;
		end else begin
			o_da_done <= i_da_valid;
			if (i_da_valid) begin
				o_da_accept <= verdict;
				hash_idx_q  <= hash_idx;
			end
		end
	end

	// ****************************************
	// receive queue flow control
	// ****************************************
	// assert below high mark, release above low mark; assert wins
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_flow_active <= 1'b0;
		end else if (i_rx_free_words < rx_flow_high_mark) begin
			o_flow_active <= 1'b1;
		end else if (i_rx_free_words > rx_flow_low_mark) begin
			o_flow_active <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_tx_flag;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(tx_cond) |=> o_tx_space_avail;
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("tx space flag missing");

	// write one clears the flag when no new rise competes with it
	property p_tx_clear;
		@(posedge i_clock) disable iff (!i_rst_n)
		wr_en && idx == IDX_INT_STATUS && pwdata[INT_TXSP_BIT] && !tx_rise
		|=> !o_tx_space_avail;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx space flag not cleared");

	property p_hash_write;
		@(posedge i_clock) disable iff (!i_rst_n)
		wr_en && idx == IDX_HASH_WORD2 |=> hash_table[47:32] == $past(pwdata[15:0]);
	endproperty
	a_hash_write: assert property (p_hash_write) else $error("hash word not stored");

	property p_hash_idx;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_da_valid |=> o_da_done && hash_idx_q == crc_top($past(i_da));
	endproperty
	a_hash_idx: assert property (p_hash_idx) else $error("hash index wrong");

	property p_hash_sel;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_da_valid && is_mcast && i_hash_mode && !accept_all && !wr_en
		|=> o_da_accept == hash_table[{hash_idx_q[5:4], hash_idx_q[3:0]}];
	endproperty
	a_hash_sel: assert property (p_hash_sel) else $error("hash bit selection wrong");

	property p_hash_drop;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_da_valid && is_mcast && i_hash_mode && !accept_all && !hash_bit
		|=> !o_da_accept;
	endproperty
	a_hash_drop: assert property (p_hash_drop) else $error("frame not dropped");

	property p_accept_all;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_da_valid && is_mcast && accept_all |=> o_da_accept;
	endproperty
	a_accept_all: assert property (p_accept_all) else $error("accept all ignored");

	property p_low_mark;
		@(posedge i_clock) disable iff (!i_rst_n)
		wr_en && idx == IDX_RX_LOW_MARK |=> rx_flow_low_mark == $past(pwdata[11:0]);
	endproperty
	a_low_mark: assert property (p_low_mark) else $error("low mark not stored");

	property p_high_read;
		@(posedge i_clock) disable iff (!i_rst_n)
		rd_setup && mapped && idx == IDX_RX_HIGH_MARK
		|=> prdata == {20'h00000, rx_flow_high_mark};
	endproperty
	a_high_read: assert property (p_high_read) else $error("high mark read wrong");

	property p_flow_on;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_rx_free_words < rx_flow_high_mark |=> o_flow_active;
	endproperty
	a_flow_on: assert property (p_flow_on) else $error("flow control not asserted");

	property p_flow_hold;
		@(posedge i_clock) disable iff (!i_rst_n)
		o_flow_active && i_rx_free_words <= rx_flow_low_mark |=> o_flow_active;
	endproperty
	a_flow_hold: assert property (p_flow_hold) else $error("flow released early");

	c_tx_flag: cover property (@(posedge i_clock) disable iff (!i_rst_n) tx_rise);
	c_drop: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		o_da_done && !o_da_accept);
	c_flow: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(o_flow_active));
	c_accept_all: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		i_da_valid && is_mcast && accept_all);
endmodule : mac_hash_filter_queue_thresholds

// ### src/mac_filter_pkg.sv
package mac_filter_pkg;
	// ****************************************
	// register indices (byte address = 4*index)
	// ****************************************
	localparam logic [9:0] IDX_TX_SPACE_REQ = 10'h09E; // tx space request
	localparam logic [9:0] IDX_HASH_WORD0   = 10'h0A0; // hash word 0
	localparam logic [9:0] IDX_HASH_WORD1   = 10'h0A2; // hash word 1
	localparam logic [9:0] IDX_HASH_WORD2   = 10'h0A4; // hash word 2
	localparam logic [9:0] IDX_HASH_WORD3   = 10'h0A6; // hash word 3
	localparam logic [9:0] IDX_RX_LOW_MARK  = 10'h0B0; // low watermark
	localparam logic [9:0] IDX_RX_HIGH_MARK = 10'h0B2; // high watermark
	localparam logic [9:0] IDX_TX_QUEUE_CTL = 10'h080; // tx queue control
	localparam logic [9:0] IDX_INT_STATUS   = 10'h082; // interrupt status
	localparam logic [9:0] IDX_RX_CTL_ONE   = 10'h084; // receive control one
	// ****************************************
	// field positions
	// ****************************************
	localparam int TXQ_MON_BIT   = 1; // tx memory available monitor
	localparam int INT_TXSP_BIT  = 6; // tx space available status
	localparam int RX_ALL_BIT    = 0; // accept all frames
	localparam int RX_ALLMC_BIT  = 1; // accept all multicast
	localparam int HASH_IDX_W    = 6; // hash index width
	localparam int MARK_W        = 12; // watermark width
	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [15:0] RST_TX_SPACE_REQ = 16'h0000; // request reset
	localparam logic [15:0] RST_HASH_WORD    = 16'h0000; // hash word reset
	localparam logic [11:0] RST_LOW_MARK     = 12'h500;  // low mark reset
	localparam logic [11:0] RST_HIGH_MARK    = 12'h300;  // high mark reset
	localparam logic [15:0] RST_CTL_WORD     = 16'h0000; // control and status reset
	localparam logic [31:0] CRC_POLY         = 32'h04C11DB7; // ethernet crc
	localparam logic [31:0] CRC_INIT         = 32'hFFFFFFFF; // crc seed
endpackage : mac_filter_pkg

// ### testbench/host_model.sv
`timescale 1ns/1ns
// ****************************************
// host processor model: apb master side
// ****************************************
module host_model (
	input  wire logic        i_clock, // system clock
	input  wire logic        pready,  // slave ready
	input  wire logic        pslverr, // slave error
	input  wire logic [31:0] prdata,  // read data
	output logic             psel,    // select
	output logic             penable, // enable
	output logic             pwrite,  // direction
	output logic      [11:0] paddr,   // byte address
	output logic      [31:0] pwdata   // write data
);
	// idle bus at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
	end
	// one transfer: setup, then access held until pready is seen
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge i_clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do @(posedge i_clock); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		// release; scramble so stale values never look like a request
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask : xfer
endmodule : host_model

// ### testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import mac_filter_pkg::*;
	logic        i_clock, i_rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr, i_rx_free_words;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] i_tx_free_words;
	logic [47:0] i_da;
	logic        i_da_valid, i_hash_mode, o_da_done, o_da_accept;
	logic        o_tx_space_avail, o_flow_active;
	logic [5:0]  idx;   // expected hash index
	logic [9:0]  hw;    // selected hash word index
	int          failures, check_count, cycles;
	localparam logic [47:0] MC = 48'h01005E000001; // group address
	host_model host (.i_clock(i_clock), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	mac_hash_filter_queue_thresholds DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .i_tx_free_words(i_tx_free_words),
		.i_rx_free_words(i_rx_free_words), .i_da_valid(i_da_valid), .i_da(i_da),
		.i_hash_mode(i_hash_mode), .o_da_done(o_da_done), .o_da_accept(o_da_accept),
		.o_tx_space_avail(o_tx_space_avail), .o_flow_active(o_flow_active));
	// ****************************************
	// clock, timeout and helpers
	// ****************************************
	always #20 i_clock = ~i_clock;
	// cut a hang short
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [9:0] i, input logic [15:0] d);
		host.xfer(1'b1, {i, 2'b00}, {16'h0000, d}, rd, err);
	endtask : wr
	task automatic rchk(input logic [9:0] i, input logic [31:0] exp);
		host.xfer(1'b0, {i, 2'b00}, 32'h0000_0000, rd, err);
		check(rd, exp);
	endtask : rchk
	// set free levels, let two sampling edges pass, compare both levels
	task automatic lv(input logic [15:0] tx, input logic [11:0] rx, input logic et, ef);
		@(posedge i_clock);
		i_tx_free_words <= tx;
		i_rx_free_words <= rx;
		@(posedge i_clock);
		@(posedge i_clock);
		#1;
		check({31'h0, o_tx_space_avail}, {31'h0, et});
		check({31'h0, o_flow_active}, {31'h0, ef});
	endtask : lv
	// one address strobe, verdict seen the cycle after
	task automatic filt(input logic [47:0] da, input logic exp);
		@(posedge i_clock);
		i_da       <= da;
		i_da_valid <= 1'b1;
		@(posedge i_clock);
		i_da_valid <= 1'b0;
		#1;
		check({31'h0, o_da_done}, 32'h0000_0001);
		check({31'h0, o_da_accept}, {31'h0, exp});
	endtask : filt
	// crc over the address, first octet first, each lsb first
	function automatic logic [5:0] hash_index(input logic [47:0] da);
		logic [31:0] c;
		logic        fb;
		c = CRC_INIT;
		for (int o = 5; o >= 0; o--) begin
			for (int b = 0; b < 8; b++) begin
				fb = c[31] ^ da[o*8+b];
				c  = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
			end
		end
		return c[31:26];
	endfunction : hash_index
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		i_clock = 1'b0;
		i_rst_n = 1'b0;
		i_tx_free_words = 16'h0000;
		i_rx_free_words = 12'h400;
		i_da_valid = 1'b0;
		i_da = 48'h0;
		i_hash_mode = 1'b0;
		failures = 0;
		check_count = 0;
		cycles = 0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rchk(IDX_TX_SPACE_REQ, 32'h0000_0000);
		rchk(IDX_HASH_WORD3, 32'h0000_0000);
		rchk(IDX_RX_LOW_MARK, 32'h0000_0500);
		rchk(IDX_RX_HIGH_MARK, 32'h0000_0300);
		host.xfer(1'b0, 12'h3FC, 32'h0000_0000, rd, err);
		check({31'h0, err}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		host.xfer(1'b0, {IDX_RX_LOW_MARK, 2'b10}, 32'h0000_0000, rd, err);
		check({31'h0, err}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		$display("test registers done");
		lv(16'h0000, 12'h300, 1'b0, 1'b0);
		lv(16'h0000, 12'h2FF, 1'b0, 1'b1);
		lv(16'h0000, 12'h500, 1'b0, 1'b1);
		lv(16'h0000, 12'h501, 1'b0, 1'b0);
		wr(IDX_RX_HIGH_MARK, 16'h0100);
		wr(IDX_RX_LOW_MARK, 16'h0ABC);
		rchk(IDX_RX_HIGH_MARK, 32'h0000_0100);
		rchk(IDX_RX_LOW_MARK, 32'h0000_0ABC);
		lv(16'h0000, 12'h0FF, 1'b0, 1'b1);
		lv(16'h0000, 12'hABD, 1'b0, 1'b0);
		$display("test flow marks done");
		wr(IDX_TX_SPACE_REQ, 16'h0040);
		rchk(IDX_TX_SPACE_REQ, 32'h0000_0040);
		lv(16'h0040, 12'hABD, 1'b0, 1'b0);
		lv(16'h003F, 12'hABD, 1'b0, 1'b0);
		wr(IDX_TX_QUEUE_CTL, 16'h0002);
		lv(16'h003F, 12'hABD, 1'b0, 1'b0);
		lv(16'h0040, 12'hABD, 1'b1, 1'b0);
		rchk(IDX_INT_STATUS, 32'h0000_0040);
		wr(IDX_INT_STATUS, 16'h0040);
		lv(16'h0050, 12'hABD, 1'b0, 1'b0);
		lv(16'h0010, 12'hABD, 1'b0, 1'b0);
		lv(16'h0050, 12'hABD, 1'b1, 1'b0);
		$display("test tx space done");
		idx = hash_index(MC);
		hw  = IDX_HASH_WORD0 + {7'h00, idx[5:4], 1'b0};
		for (int n = 0; n < 4; n++) begin
			wr(IDX_HASH_WORD0 + 10'(2 * n), (n == idx[5:4]) ? ~(16'h0001 << idx[3:0]) : 16'hFFFF);
		end
		i_hash_mode <= 1'b1;
		filt(MC, 1'b0);
		wr(hw, 16'h0001 << idx[3:0]);
		rchk(hw, {16'h0000, 16'h0001 << idx[3:0]});
		filt(MC, 1'b1);
		filt(48'h020000000000, 1'b1);
		wr(hw, 16'h0000);
		filt(MC, 1'b0);
		for (int k = 0; k < 2; k++) begin
			wr(IDX_RX_CTL_ONE, 16'h0001 << k);
			filt(MC, 1'b1);
		end
		wr(IDX_RX_CTL_ONE, 16'h0000);
		filt(MC, 1'b0);
		@(posedge i_clock);
		i_hash_mode <= 1'b0;
		filt(MC, 1'b1);
		$display("test hash filter done");
		give_verdict();
	end
endmodule : tb_top
